// *** pkg/blcfg_defs.svh ***
`ifndef BLCFG_DEFS_SVH
`define BLCFG_DEFS_SVH

// Serial bus address of this device (arbitrary value)
`define BLCFG_DEV_ADDR     7'h2a

// Byte pointers: even byte is bits 15:8, odd byte is bits 7:0
`define BLCFG_PTR_LED_HI   8'h02
`define BLCFG_PTR_LED_LO   8'h03
`define BLCFG_PTR_CFG_HI   8'h04
`define BLCFG_PTR_CFG_LO   8'h05

// Reset values
`define BLCFG_LED_RST      16'h0fff
`define BLCFG_CFG_RST      16'h08a3

// Field positions of the drive level register
`define BLCFG_CUR_HI       11
`define BLCFG_CUR_LO       0
`define BLCFG_LRSV_HI      15
`define BLCFG_LRSV_LO      12

// Field positions of the dimming and spread register
`define BLCFG_RSV_BIT      15
`define BLCFG_PSEUDO_BIT   14
`define BLCFG_RATE_HI      13
`define BLCFG_RATE_LO      12
`define BLCFG_SPAN_HI      11
`define BLCFG_SPAN_LO      10
`define BLCFG_SRC_HI       9
`define BLCFG_SRC_LO       8
`define BLCFG_RAMP_HI      7
`define BLCFG_RAMP_LO      5
`define BLCFG_DITH_HI      4
`define BLCFG_DITH_LO      2
`define BLCFG_SMOOTH_BIT   1
`define BLCFG_MINP_BIT     0

// Brightness source codes
`define BLCFG_SRC_PWM      2'h0
`define BLCFG_SRC_HOST     2'h2

// Linear ramp durations in ms, codes 1 to 7
`define BLCFG_RAMP_MS_1    10'h001
`define BLCFG_RAMP_MS_2    10'h002
`define BLCFG_RAMP_MS_3    10'h032
`define BLCFG_RAMP_MS_4    10'h064
`define BLCFG_RAMP_MS_5    10'h0c8
`define BLCFG_RAMP_MS_6    10'h12c
`define BLCFG_RAMP_MS_7    10'h1f4
`define BLCFG_SMOOTH_MIN   3'h3

// Spread modulation rate in Hz and span in tenths of a percent
`define BLCFG_HZ_0         11'h0c8
`define BLCFG_HZ_1         11'h1f4
`define BLCFG_HZ_2         11'h320
`define BLCFG_HZ_3         11'h4b0
`define BLCFG_SPAN_0       7'h21
`define BLCFG_SPAN_1       7'h2b
`define BLCFG_SPAN_2       7'h35
`define BLCFG_SPAN_3       7'h48

// Dither depth ceiling
`define BLCFG_DITH_MAX     3'h4

// Minimum pulse limit, rounded up to whole clocks
`define BLCFG_CLK_NS       100
`define BLCFG_MINP_NS      200
`define BLCFG_MINP_CYC     ((`BLCFG_MINP_NS + `BLCFG_CLK_NS - 1) / `BLCFG_CLK_NS)

`endif

// *** pkg/blcfg_pkg.sv ***
package blcfg_pkg;

	// Serial slave states
	typedef enum logic [3:0] {
		BLCFG_ST_IDLE,
		BLCFG_ST_ADDR,
		BLCFG_ST_PTR,
		BLCFG_ST_WR,
		BLCFG_ST_ACK_ON,
		BLCFG_ST_ACK_OFF,
		BLCFG_ST_RD,
		BLCFG_ST_RREL,
		BLCFG_ST_RACK,
		BLCFG_ST_RNEXT
	} blcfg_st_e;

	// Whole state of the top module
	typedef struct packed {
		blcfg_st_e   st;     // Current state
		blcfg_st_e   after;  // State after acknowledge
		logic        scl_q;  // Previous clock line
		logic        sda_q;  // Previous data line
		logic [7:0]  sh;     // Shift register
		logic [2:0]  cnt;    // Bit counter
		logic [7:0]  ptr;    // Byte pointer
		logic        drv;    // Pull data line low
		logic [15:0] led;    // Drive level register
		logic [15:0] cfg;    // Dimming and spread register
	} blcfg_top_s;

	// Whole state of the decoder
	typedef struct packed {
		logic [9:0]  ramp_ms;
		logic        smooth;
		logic        from_pwm;
		logic        from_host;
		logic [2:0]  dith;
		logic [1:0]  minp;
		logic [10:0] hz;
		logic [6:0]  span;
	} blcfg_dec_s;

endpackage

// *** hdl/blcfg_decode.sv ***
`timescale 1ns/1ns
`include "blcfg_defs.svh"

// Turns the raw configuration fields into values the dimming engine uses
module blcfg_decode
	import blcfg_pkg::*;
(
	input  wire logic        clk,       // System clock
	input  wire logic        rst,       // Synchronous reset
	input  wire logic [15:0] cfg,       // Dimming and spread register
	output logic      [9:0]  ramp_ms,   // Linear ramp time in ms
	output logic             smooth,    // Smoothed ramp in effect
	output logic             from_pwm,  // Brightness from PWM pin
	output logic             from_host, // Brightness from host register
	output logic      [2:0]  dith,      // PWM dither bits
	output logic      [1:0]  minp,      // Minimum pulse in clocks
	output logic      [10:0] hz,        // Spread modulation in Hz
	output logic      [6:0]  span       // Spread span, tenths of percent
);
	blcfg_dec_s q; // Registered state
	blcfg_dec_s s; // Next state

	wire logic [2:0] ramp_c = cfg[`BLCFG_RAMP_HI:`BLCFG_RAMP_LO]; // Ramp code
	wire logic [2:0] dith_c = cfg[`BLCFG_DITH_HI:`BLCFG_DITH_LO]; // Dither code

	// Field decode
	always_comb begin
		s = q;
		case (ramp_c)
			3'h1: s.ramp_ms = `BLCFG_RAMP_MS_1;
			3'h2: s.ramp_ms = `BLCFG_RAMP_MS_2;
			3'h3: s.ramp_ms = `BLCFG_RAMP_MS_3;
			3'h4: s.ramp_ms = `BLCFG_RAMP_MS_4;
			3'h5: s.ramp_ms = `BLCFG_RAMP_MS_5;
			3'h6: s.ramp_ms = `BLCFG_RAMP_MS_6;
			3'h7: s.ramp_ms = `BLCFG_RAMP_MS_7;
			default: s.ramp_ms = 10'h000;
		endcase
		// Short ramps are too brief to smooth, so they stay linear
		s.smooth = cfg[`BLCFG_SMOOTH_BIT] && (ramp_c >= `BLCFG_SMOOTH_MIN);
		// Reserved source codes select neither input
		s.from_pwm = (cfg[`BLCFG_SRC_HI:`BLCFG_SRC_LO] == `BLCFG_SRC_PWM);
		s.from_host = (cfg[`BLCFG_SRC_HI:`BLCFG_SRC_LO] == `BLCFG_SRC_HOST);
		// Codes above four are clamped to the deepest dither
		s.dith = (dith_c > `BLCFG_DITH_MAX) ? `BLCFG_DITH_MAX : dith_c;
		s.minp = cfg[`BLCFG_MINP_BIT] ? 2'(`BLCFG_MINP_CYC) : 2'h0;
		case (cfg[`BLCFG_RATE_HI:`BLCFG_RATE_LO])
			2'h0: s.hz = `BLCFG_HZ_0;
			2'h1: s.hz = `BLCFG_HZ_1;
			2'h2: s.hz = `BLCFG_HZ_2;
			default: s.hz = `BLCFG_HZ_3;
		endcase
		case (cfg[`BLCFG_SPAN_HI:`BLCFG_SPAN_LO])
			2'h0: s.span = `BLCFG_SPAN_0;
			2'h1: s.span = `BLCFG_SPAN_1;
			2'h2: s.span = `BLCFG_SPAN_2;
			default: s.span = `BLCFG_SPAN_3;
		endcase
		if (rst) begin
			s = '0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		q <= s;
	end

	assign ramp_ms = q.ramp_ms;
	assign smooth = q.smooth;
	assign from_pwm = q.from_pwm;
	assign from_host = q.from_host;
	assign dith = q.dith;
	assign minp = q.minp;
	assign hz = q.hz;
	assign span = q.span;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Outputs still hold their reset value on the first edge after release, so every check but dith_rng_a
	// skips the edge whose previous sample was taken in reset
	ramp_max_a: assert property (!$past(rst) && $past(ramp_c) == 3'h7 |->
		ramp_ms == `BLCFG_RAMP_MS_7)
		else $error("ramp code 7 not 500 ms");
	ramp_off_a: assert property (!$past(rst) && $past(ramp_c) == 3'h0 |->
		ramp_ms == 10'h000)
		else $error("ramp code 0 not disabled");
	smooth_sel_a: assert property (!$past(rst) && $past(cfg[`BLCFG_SMOOTH_BIT]) &&
		$past(ramp_c) >= `BLCFG_SMOOTH_MIN |-> smooth)
		else $error("long ramp lost smoothing");
	smooth_lin_a: assert property (!$past(rst) && !$past(cfg[`BLCFG_SMOOTH_BIT]) |->
		!smooth)
		else $error("smoothing while linear selected");
	dith_rng_a: assert property (dith <= `BLCFG_DITH_MAX)
		else $error("dither depth above four");
	dith_pass_a: assert property (!$past(rst) && $past(dith_c) <= `BLCFG_DITH_MAX |->
		dith == $past(dith_c))
		else $error("dither depth wrong");
	minp_on_a: assert property (!$past(rst) && $past(cfg[`BLCFG_MINP_BIT]) |->
		minp == 2'h2)
		else $error("min pulse not 200 ns");
	rate_top_a: assert property (!$past(rst) && $past(cfg[13:12]) == 2'h3 |->
		hz == `BLCFG_HZ_3)
		else $error("spread rate not 1.2 kHz");
	span_rst_a: assert property (!$past(rst) && $past(cfg[11:10]) == 2'h2 |->
		span == `BLCFG_SPAN_2)
		else $error("spread span not 5.3 percent");
	src_host_a: assert property (!$past(rst) && $past(cfg[9:8]) == `BLCFG_SRC_HOST |->
		from_host && !from_pwm)
		else $error("host source not selected");
endmodule

// *** hdl/blcfg_top.sv ***
`timescale 1ns/1ns
`include "blcfg_defs.svh"

module blcfg_top
	import blcfg_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `BLCFG_DEV_ADDR // Bus address, arbitrary value
) (
	input  wire logic        clk,                  // System clock, 10 MHz
	input  wire logic        rst,                  // Synchronous reset
	input  wire logic        scl_i,                // Serial clock line
	input  wire logic        sda_i,                // Serial data line in
	output logic             sda_o,                // Serial data out, always low
	output logic             sda_oe,               // Pull data line low
	output logic      [11:0] sink_current_code,    // Common sink current
	output logic             spread_pseudo_en,     // Pseudo-random spread
	output logic      [1:0]  spread_rate,          // Spread rate code
	output logic      [1:0]  spread_span,          // Spread span code
	output logic      [1:0]  brightness_source,    // Brightness source code
	output logic      [2:0]  ramp_code,            // Ramp time code
	output logic      [2:0]  dither_code,          // Dither depth code
	output logic             smoothed_ramp_enable, // Smoothed ramp selected
	output logic             min_pulse_dither_en,  // Min-pulse dithering on
	output logic      [9:0]  ramp_time_ms,         // Linear ramp time in ms
	output logic             ramp_smooth_active,   // Smoothing in effect
	output logic             bright_from_pwm,      // Brightness follows pin
	output logic             bright_from_host,     // Brightness follows host
	output logic      [2:0]  dither_bits,          // Dither bits in effect
	output logic      [1:0]  min_pulse_cycles,     // Pulse floor in clocks
	output logic      [10:0] spread_rate_hz,       // Spread rate in Hz
	output logic      [6:0]  spread_span_tenths    // Span, tenths of percent
);
	blcfg_top_s q;       // Registered state
	blcfg_top_s s;       // Next state
	logic       wr_en;   // Data byte written this cycle
	logic [7:0] wr_byte; // The byte written
	logic [7:0] rd_byte; // Byte at the pointer
	logic [7:0] rx_byte; // Byte completing on this edge
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;

	// Readback of one byte; unmapped pointers read zero
	function automatic logic [7:0] byte_at(input logic [7:0] p, input logic [15:0] led,
		input logic [15:0] cfg);
		case (p)
			`BLCFG_PTR_LED_HI: byte_at = led[15:8];
			`BLCFG_PTR_LED_LO: byte_at = led[7:0];
			`BLCFG_PTR_CFG_HI: byte_at = cfg[15:8];
			`BLCFG_PTR_CFG_LO: byte_at = cfg[7:0];
			default: byte_at = 8'h00;
		endcase
	endfunction

	// Bus edge and condition detection
	always_comb begin
		scl_rise = scl_i && !q.scl_q;
		scl_fall = !scl_i && q.scl_q;
		start_c = scl_i && q.scl_q && q.sda_q && !sda_i;
		stop_c = scl_i && q.scl_q && !q.sda_q && sda_i;
		rx_byte = {q.sh[6:0], sda_i};
		rd_byte = byte_at(q.ptr, q.led, q.cfg);
	end

	// Serial slave and register bank
	always_comb begin
		s = q;
		wr_en = 1'b0;
		wr_byte = rx_byte;
		s.scl_q = scl_i;
		s.sda_q = sda_i;
		if (start_c) begin
			// A start wins from any state, also a repeated one
			s.st = BLCFG_ST_ADDR;
			s.cnt = 3'h0;
			s.drv = 1'b0;
		end else if (stop_c) begin
			s.st = BLCFG_ST_IDLE;
			s.drv = 1'b0;
		end else begin
			case (q.st)
				BLCFG_ST_IDLE: begin
					s.drv = 1'b0;
				end
				BLCFG_ST_ADDR, BLCFG_ST_PTR, BLCFG_ST_WR: begin
					if (scl_rise) begin
						s.sh = rx_byte;
						s.cnt = q.cnt + 3'h1;
						if (q.cnt == 3'h7) begin
							s.st = BLCFG_ST_ACK_ON;
							s.after = BLCFG_ST_WR;
							if (q.st == BLCFG_ST_ADDR) begin
								// Foreign address: stay off the bus until next start
								if (rx_byte[7:1] != DEV_ADDR) begin
									s.st = BLCFG_ST_IDLE;
								end
								s.after = rx_byte[0] ? BLCFG_ST_RD : BLCFG_ST_PTR;
							end else if (q.st == BLCFG_ST_PTR) begin
								s.ptr = rx_byte;
							end else begin
								wr_en = 1'b1;
								s.ptr = q.ptr + 8'h01;
							end
						end
					end
				end
				BLCFG_ST_ACK_ON: begin
					// Acknowledge starts at the low phase after the eighth bit
					if (scl_fall) begin
						s.drv = 1'b1;
						s.st = BLCFG_ST_ACK_OFF;
					end
				end
				BLCFG_ST_ACK_OFF: begin
					if (scl_fall) begin
						s.drv = 1'b0;
						s.cnt = 3'h0;
						s.st = q.after;
						if (q.after == BLCFG_ST_RD) begin
							s.drv = !rd_byte[7];
							s.sh = {rd_byte[6:0], 1'b0};
						end
					end
				end
				BLCFG_ST_RD: begin
					if (scl_rise) begin
						s.cnt = q.cnt + 3'h1;
						if (q.cnt == 3'h7) begin
							s.st = BLCFG_ST_RREL;
						end
					end else if (scl_fall) begin
						s.drv = !q.sh[7];
						s.sh = {q.sh[6:0], 1'b0};
					end
				end
				BLCFG_ST_RREL: begin
					// Free the line for the master's acknowledge
					if (scl_fall) begin
						s.drv = 1'b0;
						s.st = BLCFG_ST_RACK;
					end
				end
				BLCFG_ST_RACK: begin
					if (scl_rise) begin
						s.st = sda_i ? BLCFG_ST_IDLE : BLCFG_ST_RNEXT;
						s.ptr = sda_i ? q.ptr : q.ptr + 8'h01;
					end
				end
				BLCFG_ST_RNEXT: begin
					if (scl_fall) begin
						s.drv = !rd_byte[7];
						s.sh = {rd_byte[6:0], 1'b0};
						s.cnt = 3'h0;
						s.st = BLCFG_ST_RD;
					end
				end
				default: begin
					s.st = BLCFG_ST_IDLE;
				end
			endcase
		end
		// Byte writes land at once; reserved bits are kept as written
		if (wr_en) begin
			case (q.ptr)
				`BLCFG_PTR_LED_HI: s.led[15:8] = wr_byte;
				`BLCFG_PTR_LED_LO: s.led[7:0] = wr_byte;
				`BLCFG_PTR_CFG_HI: s.cfg[15:8] = wr_byte;
				`BLCFG_PTR_CFG_LO: s.cfg[7:0] = wr_byte;
				default: ;
			endcase
		end
		if (rst) begin
			s = '0;
			s.st = BLCFG_ST_IDLE;
			s.after = BLCFG_ST_IDLE;
			s.scl_q = 1'b1;
			s.sda_q = 1'b1;
			s.led = `BLCFG_LED_RST;
			s.cfg = `BLCFG_CFG_RST;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		q <= s;
	end

	// Open-drain data line: only ever pulled low
	assign sda_o = 1'b0;
	assign sda_oe = q.drv;
	assign sink_current_code = q.led[`BLCFG_CUR_HI:`BLCFG_CUR_LO];
	assign spread_pseudo_en = q.cfg[`BLCFG_PSEUDO_BIT];
	assign spread_rate = q.cfg[`BLCFG_RATE_HI:`BLCFG_RATE_LO];
	assign spread_span = q.cfg[`BLCFG_SPAN_HI:`BLCFG_SPAN_LO];
	assign brightness_source = q.cfg[`BLCFG_SRC_HI:`BLCFG_SRC_LO];
	assign ramp_code = q.cfg[`BLCFG_RAMP_HI:`BLCFG_RAMP_LO];
	assign dither_code = q.cfg[`BLCFG_DITH_HI:`BLCFG_DITH_LO];
	assign smoothed_ramp_enable = q.cfg[`BLCFG_SMOOTH_BIT];
	assign min_pulse_dither_en = q.cfg[`BLCFG_MINP_BIT];

	// Decoded settings, one clock behind the register
	blcfg_decode u_dec (
		.clk       (clk),
		.rst       (rst),
		.cfg       (q.cfg),
		.ramp_ms   (ramp_time_ms),
		.smooth    (ramp_smooth_active),
		.from_pwm  (bright_from_pwm),
		.from_host (bright_from_host),
		.dith      (dither_bits),
		.minp      (min_pulse_cycles),
		.hz        (spread_rate_hz),
		.span      (spread_span_tenths)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_led_lo_wr;
		wr_en && q.ptr == `BLCFG_PTR_LED_LO;
	endsequence
	sequence s_cfg_hi_wr;
		wr_en && q.ptr == `BLCFG_PTR_CFG_HI;
	endsequence

	led_rst_a: assert property ($past(rst) |->
		sink_current_code == 12'hfff && q.led[15:12] == 4'h0)
		else $error("drive level reset wrong");
	cfg_rst_a: assert property ($past(rst) |-> q.cfg == `BLCFG_CFG_RST)
		else $error("config reset wrong");
	led_wr_a: assert property (s_led_lo_wr |->
		##1 sink_current_code[7:0] == $past(wr_byte))
		else $error("drive level low byte not stored");
	led_rsv_a: assert property (wr_en && q.ptr == `BLCFG_PTR_LED_HI |=>
		q.led[15:12] == $past(wr_byte[7:4]))
		else $error("reserved drive bits not stored");
	cfg_hi_a: assert property (s_cfg_hi_wr |->
		##1 q.cfg[15] == $past(wr_byte[7]) && spread_pseudo_en == $past(wr_byte[6]))
		else $error("config high byte not stored");
	cfg_lo_a: assert property (wr_en && q.ptr == `BLCFG_PTR_CFG_LO |=>
		ramp_code == $past(wr_byte[7:5]) && min_pulse_dither_en == $past(wr_byte[0]))
		else $error("config low byte not stored");
	ack_pulse_a: assert property (q.st == BLCFG_ST_ACK_ON && scl_fall |=> sda_oe && q.st == BLCFG_ST_ACK_OFF)
		else $error("acknowledge not driven");
	cfg_hold_a: assert property (!wr_en |=> $stable(q.cfg) && $stable(q.led))
		else $error("register changed without write");
endmodule

// *** sim/blcfg_host.sv ***
`timescale 1ns/1ns

// Bus master standing in for the host controller
module blcfg_host (
	input  wire logic clk,      // System clock
	input  wire logic sda,      // Resolved data line
	output logic      scl,      // Serial clock line
	output logic      sda_pull  // High while host pulls data low
);
	// Bus released at time zero; the pull-up holds data high
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// Whole clocks only, so every change lands just after an edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Start or repeated start: data falls while clock is high
	task automatic start();
		sda_pull <= 1'b0;
		tick(5);
		scl <= 1'b1;
		tick(5);
		sda_pull <= 1'b1;
		tick(5);
		scl <= 1'b0;
		tick(5);
	endtask

	// One bit; five clocks a phase keeps levels far above the two-clock floor
	task automatic bit_x(input logic b, output logic r);
		sda_pull <= ~b;
		tick(5);
		scl <= 1'b1;
		tick(3);
		r = sda;
		tick(2);
		scl <= 1'b0;
		tick(5);
	endtask

	// Byte MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
			output logic [7:0] rx, output logic ack_out);
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], rx[i]);
		end
		bit_x(ack_in, ack_out);
	endtask

	// Stop: data rises while clock is high, bus left idle
	task automatic stop();
		sda_pull <= 1'b1;
		tick(5);
		scl <= 1'b1;
		tick(5);
		sda_pull <= 1'b0;
		tick(5);
	endtask
endmodule

// *** sim/test_blcfg_top.sv ***
`timescale 1ns/1ns
`include "blcfg_defs.svh"

module test_blcfg_top;
	import blcfg_pkg::*;

	// One table row: register value and the decoded figures it should give
	typedef struct packed {
		logic [15:0] cfg;
		logic [9:0]  ms;
		logic [10:0] hz;
		logic [6:0]  span;
	} blcfg_row_s;

	logic        clk;                  // Bench clock
	logic        rst;                  // Bench reset
	logic        scl;                  // Clock line from host
	logic        sda_pull;             // Host pulling data low
	wire         sda;                  // Resolved data line
	logic        sda_o;                // Device data value
	logic        sda_oe;               // Device pulling data low
	logic [11:0] sink_current_code;    // Drive level
	logic        spread_pseudo_en;     // Raw fields follow
	logic [1:0]  spread_rate;
	logic [1:0]  spread_span;
	logic [1:0]  brightness_source;
	logic [2:0]  ramp_code;
	logic [2:0]  dither_code;
	logic        smoothed_ramp_enable;
	logic        min_pulse_dither_en;
	logic [9:0]  ramp_time_ms;         // Decoded figures follow
	logic        ramp_smooth_active;
	logic        bright_from_pwm;
	logic        bright_from_host;
	logic [2:0]  dither_bits;
	logic [1:0]  min_pulse_cycles;
	logic [10:0] spread_rate_hz;
	logic [6:0]  spread_span_tenths;
	logic [3:0]  nak;                  // Acknowledge slots of last write
	logic [15:0] rd;                   // Last value read back
	int          compares;             // Comparisons made
	int          n_mismatch;           // Comparisons failed
	int          cycles;               // Clocks since time zero

	// Rows avoid 1/2 ms with smoothing and reserved source codes
	blcfg_row_s rows [8] = '{
		'{16'h4000, 10'h000, 11'h0c8, 7'h21},
		'{16'h9625, 10'h001, 11'h1f4, 7'h2b},
		'{16'h6848, 10'h002, 11'h320, 7'h35},
		'{16'hbe6f, 10'h032, 11'h4b0, 7'h48},
		'{16'h0c92, 10'h064, 11'h0c8, 7'h48},
		'{16'h5aa1, 10'h0c8, 11'h1f4, 7'h35},
		'{16'h24c7, 10'h12c, 11'h320, 7'h2b},
		'{16'h72ea, 10'h1f4, 11'h4b0, 7'h21}
	};

	// Open-drain data line: pull-up unless someone pulls low
	assign sda = ~(sda_oe | sda_pull);

	// Free-running 10 MHz clock
	always #50 clk = ~clk;

	blcfg_host u_host (
		.clk      (clk),
		.sda      (sda),
		.scl      (scl),
		.sda_pull (sda_pull)
	);

	blcfg_top dut_u (
		.clk                  (clk),
		.rst                  (rst),
		.scl_i                (scl),
		.sda_i                (sda),
		.sda_o                (sda_o),
		.sda_oe               (sda_oe),
		.sink_current_code    (sink_current_code),
		.spread_pseudo_en     (spread_pseudo_en),
		.spread_rate          (spread_rate),
		.spread_span          (spread_span),
		.brightness_source    (brightness_source),
		.ramp_code            (ramp_code),
		.dither_code          (dither_code),
		.smoothed_ramp_enable (smoothed_ramp_enable),
		.min_pulse_dither_en  (min_pulse_dither_en),
		.ramp_time_ms         (ramp_time_ms),
		.ramp_smooth_active   (ramp_smooth_active),
		.bright_from_pwm      (bright_from_pwm),
		.bright_from_host     (bright_from_host),
		.dither_bits          (dither_bits),
		.min_pulse_cycles     (min_pulse_cycles),
		.spread_rate_hz       (spread_rate_hz),
		.spread_span_tenths   (spread_span_tenths)
	);

	// Single compare for every kind of value, widened to 16 bits
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Whole 16-bit register write, high byte first
	task automatic reg_wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] v);
		logic [7:0] rx;
		u_host.start();
		u_host.xfer({dev, 1'b0}, 1'b1, rx, nak[3]);
		u_host.xfer(ptr, 1'b1, rx, nak[2]);
		u_host.xfer(v[15:8], 1'b1, rx, nak[1]);
		u_host.xfer(v[7:0], 1'b1, rx, nak[0]);
		u_host.stop();
	endtask

	// Pointer write, repeated start, two bytes read; last byte refused by host
	task automatic reg_rd(input logic [7:0] ptr, output logic [15:0] v);
		logic [7:0] rx;
		logic       a;
		u_host.start();
		u_host.xfer({`BLCFG_DEV_ADDR, 1'b0}, 1'b1, rx, a);
		u_host.xfer(ptr, 1'b1, rx, a);
		u_host.start();
		u_host.xfer({`BLCFG_DEV_ADDR, 1'b1}, 1'b1, rx, a);
		u_host.xfer(8'hff, 1'b0, v[15:8], a);
		u_host.xfer(8'hff, 1'b1, v[7:0], a);
		u_host.stop();
	endtask

	// Counts, verdict and end of run
	task automatic test_done();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard: a full run needs about 15100 clocks
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_mismatch++;
			$display("FAIL timeout expected end seen hang");
			test_done();
		end
	end

	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		u_host.tick(2);
		// Table rows: every ramp, rate and span code at least once
		for (int i = 0; i < 8; i++) begin
			reg_wr(`BLCFG_DEV_ADDR, `BLCFG_PTR_CFG_HI, rows[i].cfg);
			chk("ack", 16'h0000, {12'h000, nak});
			chk("fields", {1'b0, rows[i].cfg[14:0]}, {1'b0, spread_pseudo_en, spread_rate,
				spread_span, brightness_source, ramp_code, dither_code, smoothed_ramp_enable,
				min_pulse_dither_en});
			chk("ramp_ms", {6'h00, rows[i].ms}, {6'h00, ramp_time_ms});
			chk("rate_hz", {5'h00, rows[i].hz}, {5'h00, spread_rate_hz});
			chk("span", {9'h000, rows[i].span}, {9'h000, spread_span_tenths});
			chk("dither", {13'h0000, rows[i].cfg[4:2]}, {13'h0000, dither_bits});
			chk("source", {14'h0000, rows[i].cfg[9:8] == 2'h2, rows[i].cfg[9:8] == 2'h0},
				{14'h0000, bright_from_host, bright_from_pwm});
			chk("smooth", {15'h0000, rows[i].cfg[1]},
				{15'h0000, ramp_smooth_active});
			chk("min_pulse", {14'h0000, rows[i].cfg[0], 1'b0},
				{14'h0000, min_pulse_cycles});
			reg_rd(`BLCFG_PTR_CFG_HI, rd);
			chk("cfg_read", rows[i].cfg, rd);
			$display("row %0d done", i);
		end
		// Drive level with reserved bits set
		reg_wr(`BLCFG_DEV_ADDR, `BLCFG_PTR_LED_HI, 16'hf123);
		chk("ack", 16'h0000, {12'h000, nak});
		chk("sink", 16'h0123, {4'h0, sink_current_code});
		reg_rd(`BLCFG_PTR_LED_HI, rd);
		chk("led_read", 16'hf123, rd);
		$display("drive level test done");
		// Foreign address must be ignored entirely
		reg_wr(`BLCFG_DEV_ADDR ^ 7'h01, `BLCFG_PTR_LED_HI, 16'h0456);
		chk("nak", 16'h000f, {12'h000, nak});
		chk("sink", 16'h0123, {4'h0, sink_current_code});
		$display("address test done");
		// Reset in mid-run restores every documented value
		rst <= 1'b1;
		u_host.tick(16);
		rst <= 1'b0;
		u_host.tick(3);
		chk("sink", 16'h0fff, {4'h0, sink_current_code});
		chk("fields", 16'h08a3, {1'b0, spread_pseudo_en, spread_rate, spread_span,
			brightness_source, ramp_code, dither_code, smoothed_ramp_enable,
			min_pulse_dither_en});
		chk("ramp_ms", 16'h00c8, {6'h00, ramp_time_ms});
		chk("rate_hz", 16'h00c8, {5'h00, spread_rate_hz});
		chk("span", 16'h0035, {9'h000, spread_span_tenths});
		chk("source", 16'h0001, {14'h0000, bright_from_host, bright_from_pwm});
		chk("min_pulse", 16'h0002, {14'h0000, min_pulse_cycles});
		chk("sda_o", 16'h0000, {15'h0000, sda_o});
		reg_rd(`BLCFG_PTR_LED_HI, rd);
		chk("led_read", 16'h0fff, rd);
		reg_rd(`BLCFG_PTR_CFG_HI, rd);
		chk("cfg_read", 16'h08a3, rd);
		$display("reset test done");
		// Dither codes above four clamp; the byte past the odd pointer goes nowhere
		reg_wr(`BLCFG_DEV_ADDR, `BLCFG_PTR_CFG_LO, 16'hfc55);
		chk("ack", 16'h0000, {12'h000, nak});
		chk("dither", 16'h0004, {13'h0000, dither_bits});
		chk("ramp_ms", 16'h01f4, {6'h00, ramp_time_ms});
		chk("smooth", 16'h0000, {15'h0000, ramp_smooth_active});
		chk("min_pulse", 16'h0000, {14'h0000, min_pulse_cycles});
		reg_rd(`BLCFG_PTR_CFG_LO, rd);
		chk("cfg_read", 16'hfc00, rd);
		$display("clamp test done");
		test_done();
	end
endmodule
